//--- pkg/ssc_pkg.sv
// Constants, types and field decoding for the synthesizer configuration bank
package ssc_pkg;

   // ==========================================================
   // Register offsets (7-bit serial address)
   localparam logic [6:0] OFS_STATUS  = 7'h00;
   localparam logic [6:0] OFS_STATCFG = 7'h01;
   localparam logic [6:0] OFS_PWR     = 7'h02;
   localparam logic [6:0] OFS_MOD     = 7'h03;
   localparam logic [6:0] OFS_REGUL   = 7'h04;
   localparam logic [6:0] OFS_SEED    = 7'h05;
   localparam logic [6:0] OFS_RDIV    = 7'h06;
   localparam logic [6:0] OFS_NDIV    = 7'h07;
   localparam logic [6:0] OFS_NUM_H   = 7'h08;
   localparam logic [6:0] OFS_NUM_M   = 7'h09;
   localparam logic [6:0] OFS_NUM_L   = 7'h0A;
   localparam logic [6:0] OFS_REFOUT  = 7'h0B;
   localparam logic [6:0] OFS_LOCK    = 7'h0C;
   localparam logic [6:0] OFS_PUMP    = 7'h0D;

   // ==========================================================
   // Field positions
   localparam int B_LOCK_ROUTE = 2;
   localparam int B_SOFT_MUTE  = 1;
   localparam int B_INT_MODE   = 0;
   localparam int B_DITHER     = 1;
   localparam int B_AUTO_RST   = 2;
   localparam int B_MAN_RST    = 3;
   localparam int B_REG_VOLT   = 3;
   localparam int B_PUMP_LIN   = 2;
   localparam int B_REG_EN     = 1;
   localparam int B_RDIV       = 3;
   localparam int B_OUT_DIV    = 0;
   localparam int B_OUT_PWR    = 3;
   localparam int B_REF_REF_FILTER_SEL   = 6;
   localparam int B_REF_BOOST  = 7;
   localparam int B_PUMP_CUR   = 0;
   localparam int B_LK_COUNT   = 4;
   localparam int B_LK_WIN     = 6;
   localparam int B_PUMP_DN    = 1;
   localparam int B_PUMP_UP    = 2;
   localparam int B_PUMP_RST   = 3;
   localparam int B_PUMP_INV   = 4;
   localparam int B_PUMP_MID   = 5;
   localparam int B_CLAMP_LO   = 6;
   localparam int B_CLAMP_HI   = 7;

   // ==========================================================
   // Values after reset
   localparam logic [7:0] RST_REG  = 8'h00;
   localparam logic [7:0] RST_SEED = 8'h5A;
   localparam logic       RST_BIT  = 1'b0;

   // ==========================================================
   // Lock-count choices, detector cycles per select value
   localparam logic [11:0] LK_CNT_0 = 12'h010;
   localparam logic [11:0] LK_CNT_1 = 12'h020;
   localparam logic [11:0] LK_CNT_2 = 12'h100;
   localparam logic [11:0] LK_CNT_3 = 12'h800;

   typedef logic [15:0][7:0] ssc_regs_t;

   typedef struct packed {
      logic        stat_lock_route;
      logic        soft_output_mute;
      logic [6:0]  power_down;
      logic        auto_mod_reset_en;
      logic        manual_mod_reset;
      logic        dither_enable;
      logic        integer_mode_sel;
      logic [7:0]  seed;
      logic        regulator_enable;
      logic [1:0]  regulator_voltage_sel;
      logic        pump_linearity_en;
      logic [4:0]  ref_div;
      logic [10:0] n_div;
      logic [17:0] numerator;
      logic        ref_boost;
      logic        ref_filter_sel;
      logic [1:0]  output_power_sel;
      logic [2:0]  output_divider_sel;
      logic [1:0]  lock_window_sel;
      logic [1:0]  lock_count_sel;
      logic [3:0]  pump_current_sel;
      logic        pump_polarity_invert;
      logic        pump_high_clamp_en;
      logic        pump_low_clamp_en;
      logic        pump_mid_bias;
      logic        pump_reset;
      logic        pump_force_up;
      logic        pump_force_down;
   } ssc_cfg_s;

   function automatic logic [7:0] ssc_rst_val(input logic [3:0] idx);
      ssc_rst_val = (idx == OFS_SEED[3:0]) ? RST_SEED : RST_REG;
   endfunction : ssc_rst_val

   function automatic ssc_cfg_s ssc_decode(input ssc_regs_t r);
      ssc_cfg_s c;
      c.stat_lock_route       = r[1][B_LOCK_ROUTE];
      c.soft_output_mute      = r[2][B_SOFT_MUTE];
      c.power_down            = {r[2][7:2], r[2][0]};
      c.auto_mod_reset_en     = r[3][B_AUTO_RST];
      c.manual_mod_reset      = r[3][B_MAN_RST];
      c.dither_enable         = r[3][B_DITHER];
      c.integer_mode_sel      = r[3][B_INT_MODE];
      c.seed                  = r[5];
      c.regulator_enable      = r[4][B_REG_EN];
      c.regulator_voltage_sel = r[4][B_REG_VOLT +: 2];
      c.pump_linearity_en     = r[4][B_PUMP_LIN];
      c.ref_div               = r[6][B_RDIV +: 5];
      c.n_div                 = {r[6][2:0], r[7]};
      c.numerator             = {r[8][5:0], r[9], r[10][7:4]};
      c.ref_boost             = r[11][B_REF_BOOST];
      c.ref_filter_sel        = r[11][B_REF_REF_FILTER_SEL];
      c.output_power_sel      = r[11][B_OUT_PWR +: 2];
      c.output_divider_sel    = r[11][B_OUT_DIV +: 3];
      c.lock_window_sel       = r[12][B_LK_WIN +: 2];
      c.lock_count_sel        = r[12][B_LK_COUNT +: 2];
      c.pump_current_sel      = r[12][B_PUMP_CUR +: 4];
      c.pump_polarity_invert  = r[13][B_PUMP_INV];
      c.pump_high_clamp_en    = r[13][B_CLAMP_HI];
      c.pump_low_clamp_en     = r[13][B_CLAMP_LO];
      c.pump_mid_bias         = r[13][B_PUMP_MID];
      c.pump_reset            = r[13][B_PUMP_RST];
      c.pump_force_up         = r[13][B_PUMP_UP];
      c.pump_force_down       = r[13][B_PUMP_DN];
      return c;
   endfunction : ssc_decode

endpackage : ssc_pkg

//--- hdl/ssc_config_bank.sv
// Serial configuration bank, lock detector and modulator core of the synthesizer
`timescale 1ns/1ps
// Function
// - Lock-route bit set drives status pin high while lock flag asserts.
// - Output muted while soft mute is 1 or mute pin is low.
// - Auto reset enabled: modulator reset when write burst ends.
// - With auto reset, host need not set manual modulator reset.
// - Dither enable and integer mode bits; 1 and 0 give dithered fractional.
// - Eight-bit seed initialises modulator dither generator; default usable.
// - Regulator enable bit and two-bit regulator voltage field.
// - Lock only while phase offset stays inside window set by two-bit field.
// - Two-bit lock-count field selects detector cycles; value 1 gives 32.
// - Four-bit pump current field; value 5 selects 5.6 mA.
// - Pump inversion bit reverses up and down polarity.
// - Separate high and low clamp enables; both zero disables clamping.
// - Serial port supports auto-incrementing write bursts.
// - Reference filter select bit; 0 suits a 100 MHz reference.
// - Two-bit output power (3 is maximum) and three-bit output divider.
// - Host enables all blocks, may keep mute until programming completes.
// - Fractional mode changes divide ratio every detector cycle.
// - 18-bit numerator; fraction is numerator over two to the eighteenth.
// - Integer mode uses zero fraction, integer divide count only.
module ssc_config_bank (
   input  wire logic              mclk_in,
   input  wire logic              sys_rst_in,
   input  wire logic              spi_sclk_in,
   input  wire logic              spi_cs_n_in,
   input  wire logic              spi_mosi_in,
   output logic                   spi_miso_out,
   output logic                   spi_miso_oe_out,
   input  wire logic              mute_n_in,
   input  wire logic              pfd_tick_in,
   input  wire logic              phase_in_window_in,
   output logic                   lock_out,
   output logic                   stat_out,
   output logic                   rf_mute_out,
   output logic                   mod_reset_out,
   output logic [11:0]            fb_div_out,
   output ssc_pkg::ssc_cfg_s      cfg_out
);
   import ssc_pkg::*;

   // ==========================================================
   // Link-domain state
   typedef struct packed {
      logic [2:0] bit_cnt;
      logic [6:0] shift;
      logic [6:0] addr;
      logic       data_phase;
      logic       rd;
      logic [7:0] miso_sh;
   } ssc_frame_s;

   typedef struct packed {
      ssc_regs_t  regs;
      logic [2:0] lock_sync;
      logic       lock_lvl;
   } ssc_link_s;

   // ==========================================================
   // System-domain state
   typedef struct packed {
      logic [2:0]  cs_sync;
      logic        cs_lvl;
      logic [2:0]  mute_sync;
      logic        mute_lvl;
      ssc_regs_t   snap;
      logic [11:0] lk_cnt;
      logic        locked;
      logic [17:0] acc;
      logic [7:0]  lfsr;
      logic        mod_rst;
      logic [11:0] fb_div;
   } ssc_sys_s;

   ssc_frame_s fr_r;
   ssc_frame_s fr_nxt;
   ssc_link_s  lk_r;
   ssc_link_s  lk_nxt;
   ssc_sys_s   sy_r;
   ssc_sys_s   sy_nxt;
   logic       frame_rst;

   function automatic logic [7:0] rd_byte(input ssc_regs_t r, input logic [6:0] a,
                                          input logic lock_lvl);
      if (a == OFS_STATUS)
         rd_byte = {7'h00, lock_lvl};
      else if (a <= OFS_PUMP)
         rd_byte = r[a[3:0]];
      else
         rd_byte = 8'h00;
   endfunction : rd_byte

   function automatic logic [11:0] lk_target(input logic [1:0] sel);
      unique case (sel)
         2'h0: lk_target = LK_CNT_0;
         2'h1: lk_target = LK_CNT_1;
         2'h2: lk_target = LK_CNT_2;
         2'h3: lk_target = LK_CNT_3;
      endcase
   endfunction : lk_target

   // Frame state clears whenever select is high; the link clock stops between frames
   assign frame_rst = sys_rst_in | spi_cs_n_in;

   // ==========================================================
   // Serial shifter, link domain
   always_comb begin
      logic [7:0] byte_in;
      logic [6:0] next_addr;
      byte_in   = {fr_r.shift, spi_mosi_in};
      next_addr = 7'h00;
      fr_nxt    = fr_r;
      lk_nxt    = lk_r;
      lk_nxt.lock_sync = {lk_r.lock_sync[1:0], sy_r.locked};
      if (lk_r.lock_sync[1] == lk_r.lock_sync[2]) begin
         lk_nxt.lock_lvl = lk_r.lock_sync[2];
      end
      fr_nxt.bit_cnt = fr_r.bit_cnt + 3'h1;
      fr_nxt.shift   = byte_in[6:0];
      fr_nxt.miso_sh = {fr_r.miso_sh[6:0], 1'b0};
      if (fr_r.bit_cnt == 3'h7) begin
         if (!fr_r.data_phase) begin
            fr_nxt.addr       = byte_in[7:1];
            fr_nxt.rd         = byte_in[0];
            fr_nxt.data_phase = 1'b1;
            fr_nxt.miso_sh    = rd_byte(lk_r.regs, byte_in[7:1], lk_r.lock_lvl);
         end else begin
            next_addr      = fr_r.addr + 7'h01;
            fr_nxt.addr    = next_addr;
            fr_nxt.miso_sh = rd_byte(lk_r.regs, next_addr, lk_r.lock_lvl);
            if (!fr_r.rd && fr_r.addr != OFS_STATUS && fr_r.addr <= OFS_PUMP) begin
               lk_nxt.regs[fr_r.addr[3:0]] = byte_in;
            end
         end
      end
   end

   always_ff @(posedge spi_sclk_in or posedge frame_rst) begin
      if (frame_rst) begin
         fr_r <= '0;
      end else begin
         fr_r <= fr_nxt;
      end
   end

   always_ff @(posedge spi_sclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         for (int i = 0; i < 16; i++) begin
            lk_r.regs[i] <= ssc_rst_val(4'(i));
         end
         lk_r.lock_sync <= '0;
         lk_r.lock_lvl  <= RST_BIT;
      end else begin
         lk_r <= lk_nxt;
      end
   end

   assign spi_miso_out    = fr_r.miso_sh[7];
   assign spi_miso_oe_out = ~spi_cs_n_in & fr_r.rd;

   // ==========================================================
   // Snapshot, lock detector and modulator, system domain
   always_comb begin
      ssc_cfg_s    c;
      ssc_cfg_s    cur;
      logic        burst_end;
      logic        mod_hold;
      logic [18:0] sum;
      logic [17:0] frac;
      cur       = ssc_decode(sy_r.snap);
      c         = cur;
      burst_end = 1'b0;
      mod_hold  = sy_r.mod_rst;
      sum       = 19'h00000;
      frac      = cur.numerator;
      sy_nxt = sy_r;
      sy_nxt.cs_sync   = {sy_r.cs_sync[1:0], spi_cs_n_in};
      sy_nxt.mute_sync = {sy_r.mute_sync[1:0], mute_n_in};
      if (sy_r.cs_sync[1] == sy_r.cs_sync[2]) begin
         sy_nxt.cs_lvl = sy_r.cs_sync[2];
      end
      if (sy_r.mute_sync[1] == sy_r.mute_sync[2]) begin
         sy_nxt.mute_lvl = sy_r.mute_sync[2];
      end
      // Link registers are frozen once select is high, so the copy is stable
      burst_end = sy_r.cs_sync[1] & sy_r.cs_sync[2] & ~sy_r.cs_lvl;
      if (burst_end) begin
         sy_nxt.snap = lk_r.regs;
      end
      c = ssc_decode(sy_nxt.snap);
      // Manual reset bit holds the modulator, the automatic one pulses at burst end
      sy_nxt.mod_rst = (burst_end & c.auto_mod_reset_en) | c.manual_mod_reset;
      mod_hold = sy_r.mod_rst;

      // Lock qualifies on consecutive in-window detector cycles
      if (pfd_tick_in) begin
         if (!phase_in_window_in) begin
            sy_nxt.lk_cnt = 12'h000;
            sy_nxt.locked = 1'b0;
         end else if (sy_r.lk_cnt >= lk_target(cur.lock_count_sel) - 12'h001) begin
            // This tick completes the selected count of qualifying cycles
            sy_nxt.locked = 1'b1;
         end else begin
            sy_nxt.lk_cnt = sy_r.lk_cnt + 12'h001;
         end
      end

      if (cur.integer_mode_sel) begin
         frac = 18'h00000;
      end
      sum = {1'b0, sy_r.acc} + {1'b0, frac};
      if (cur.dither_enable && !cur.integer_mode_sel) begin
         sum = sum + {18'h00000, sy_r.lfsr[0]};
      end
      if (mod_hold) begin
         sy_nxt.acc    = 18'h00000;
         sy_nxt.lfsr   = cur.seed;
         sy_nxt.fb_div = {1'b0, cur.n_div};
      end else if (pfd_tick_in) begin
         sy_nxt.acc    = sum[17:0];
         sy_nxt.lfsr   = {sy_r.lfsr[6:0],
                          sy_r.lfsr[7] ^ sy_r.lfsr[5] ^ sy_r.lfsr[4] ^ sy_r.lfsr[3]};
         // Carry out of the fraction adds one to this cycle's divide count
         sy_nxt.fb_div = {1'b0, cur.n_div} + {11'h000, sum[18]};
      end
   end

   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         sy_r.cs_sync   <= 3'h7;
         sy_r.cs_lvl    <= 1'b1;
         sy_r.mute_sync <= 3'h0;
         sy_r.mute_lvl  <= 1'b0;
         for (int i = 0; i < 16; i++) begin
            sy_r.snap[i] <= ssc_rst_val(4'(i));
         end
         sy_r.lk_cnt    <= 12'h000;
         sy_r.locked    <= RST_BIT;
         sy_r.acc       <= 18'h00000;
         sy_r.lfsr      <= RST_SEED;
         sy_r.mod_rst   <= 1'b1;
         sy_r.fb_div    <= 12'h000;
      end else begin
         sy_r <= sy_nxt;
      end
   end

   // ==========================================================
   // Outputs
   always_comb begin
      ssc_cfg_s c;
      c = ssc_decode(sy_r.snap);
      // Pump current, polarity, clamps, forces, reference, output and regulator fields
      cfg_out       = c;
      lock_out      = sy_r.locked;
      stat_out      = c.stat_lock_route & sy_r.locked;
      rf_mute_out   = c.soft_output_mute | ~sy_r.mute_lvl;
      mod_reset_out = sy_r.mod_rst;
      fb_div_out    = sy_r.fb_div;
   end

endmodule : ssc_config_bank

//--- test/ssc_config_bank_sva.sv
// Port assertions for the synthesizer configuration bank
`timescale 1ns/1ps
module ssc_config_bank_sva (
   input wire logic              mclk_in,
   input wire logic              sys_rst_in,
   input wire logic              spi_sclk_in,
   input wire logic              spi_cs_n_in,
   input wire logic              spi_mosi_in,
   input wire logic              spi_miso_out,
   input wire logic              spi_miso_oe_out,
   input wire logic              mute_n_in,
   input wire logic              pfd_tick_in,
   input wire logic              phase_in_window_in,
   input wire logic              lock_out,
   input wire logic              stat_out,
   input wire logic              rf_mute_out,
   input wire logic              mod_reset_out,
   input wire logic [11:0]       fb_div_out,
   input wire ssc_pkg::ssc_cfg_s cfg_out
);
   import ssc_pkg::*;
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (sys_rst_in);
   // ==========================================================
   // Run of consecutive in-window detector ticks
   logic [11:0]      run_r;
   logic [3:0][11:0] tgt;
   assign tgt = {LK_CNT_3, LK_CNT_2, LK_CNT_1, LK_CNT_0};
   always_ff @(posedge mclk_in or posedge sys_rst_in)
      if (sys_rst_in)
         run_r <= 12'h000;
      else if (pfd_tick_in)
         run_r <= phase_in_window_in ? run_r + 12'h001 : 12'h000;
   sequence burst_end_s;
      $rose(spi_cs_n_in) && cfg_out.auto_mod_reset_en;
   endsequence
   sequence long_run_s;
      pfd_tick_in && phase_in_window_in && run_r >= tgt[cfg_out.lock_count_sel] - 12'h001;
   endsequence
   // ==========================================================
   // Assertions
   stat_high_a: assert property ((cfg_out.stat_lock_route && lock_out)[*2] |-> stat_out)
      else $error("status pin low while locked");
   stat_low_a: assert property ((!lock_out)[*2] |-> !stat_out)
      else $error("status pin high without lock");
   soft_mute_a: assert property (cfg_out.soft_output_mute[*2] |-> rf_mute_out)
      else $error("output live with soft mute set");
   pin_mute_a: assert property ((!mute_n_in)[*7] |-> rf_mute_out)
      else $error("output live with mute pin low");
   unmute_a: assert property ((mute_n_in && !cfg_out.soft_output_mute)[*7] |-> !rf_mute_out)
      else $error("output muted with both mutes released");
   auto_pulse_a: assert property (burst_end_s |-> ##[1:8] mod_reset_out)
      else $error("no modulator reset after burst");
   pulse_once_a: assert property ($rose(mod_reset_out) && !cfg_out.manual_mod_reset |=> !mod_reset_out)
      else $error("modulator reset pulse too long");
   manual_lvl_a: assert property (cfg_out.manual_mod_reset[*2] |-> mod_reset_out)
      else $error("manual modulator reset not held");
   int_div_a: assert property (pfd_tick_in && cfg_out.integer_mode_sel |-> ##2 fb_div_out == {1'b0, cfg_out.n_div})
      else $error("integer mode divide count wrong");
   lock_drop_a: assert property (pfd_tick_in && !phase_in_window_in |-> ##2 !lock_out)
      else $error("lock kept after out-of-window tick");
   lock_early_a: assert property ($rose(lock_out) |-> run_r >= tgt[cfg_out.lock_count_sel])
      else $error("lock declared too early");
   lock_late_a: assert property (long_run_s |=> lock_out)
      else $error("lock not declared after count");
endmodule : ssc_config_bank_sva
bind ssc_config_bank ssc_config_bank_sva sva_i (
   .mclk_in            (mclk_in),
   .sys_rst_in         (sys_rst_in),
   .spi_sclk_in        (spi_sclk_in),
   .spi_cs_n_in        (spi_cs_n_in),
   .spi_mosi_in        (spi_mosi_in),
   .spi_miso_out       (spi_miso_out),
   .spi_miso_oe_out    (spi_miso_oe_out),
   .mute_n_in          (mute_n_in),
   .pfd_tick_in        (pfd_tick_in),
   .phase_in_window_in (phase_in_window_in),
   .lock_out           (lock_out),
   .stat_out           (stat_out),
   .rf_mute_out        (rf_mute_out),
   .mod_reset_out      (mod_reset_out),
   .fb_div_out         (fb_div_out),
   .cfg_out            (cfg_out)
);

//--- test/ssc_spi_host.sv
// Serial host model that drives configuration frames
`timescale 1ns/1ps
module ssc_spi_host (
   output logic      sclk_out,
   output logic      cs_n_out,
   output logic      mosi_out,
   input  wire logic miso_in
);
   initial begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      mosi_out = 1'b0;
   end
   // One frame of whole bytes, 48 ns bit period, clock still between frames
   task automatic frame(input logic [7:0] q[$], output logic [7:0] rd);
      logic [15:0] sh;
      sh       = 16'h0000;
      cs_n_out = 1'b0;
      foreach (q[k]) begin
         for (int i = 7; i >= 0; i--) begin
            mosi_out = q[k][i];
            #24 sclk_out = 1'b1;
            #24 sh = {sh[14:0], miso_in};
            sclk_out = 1'b0;
         end
      end
      #24 cs_n_out = 1'b1;
      // Released data line must not look like a held value
      mosi_out = ~mosi_out;
      rd       = sh[8:1];
      #100;
   endtask : frame
endmodule : ssc_spi_host

//--- test/ssc_config_bank_bench.sv
// Self-checking bench for the synthesizer configuration bank
`timescale 1ns/1ps
module ssc_config_bank_bench;
   import ssc_pkg::*;
   // ==========================================================
   // Signals
   logic        mclk   = 1'b0;
   logic        rst    = 1'b1;
   logic        mute_n = 1'b0;
   logic        tick   = 1'b0;
   logic        win    = 1'b0;
   logic        sclk, cs_n, mosi, miso, miso_oe, lock, stat, rfm, modr;
   logic [11:0] fb;
   ssc_cfg_s    cfg;
   logic [7:0]  rd;
   int          n_fail = 0;
   int          samples_checked = 0;
   int          n_hi = 0;
   int          k;
   logic [7:0]  tbl [$] = '{8'hFF, 8'h04, 8'h02, 8'h02, 8'h0E, 8'h5A, 8'h10, 8'h30,
                            8'h13, 8'h64, 8'h60, 8'h99, 8'h55, 8'h10, 8'hFF};
   always #5 mclk = ~mclk;
   always @(posedge mclk)
      if (rst)
         n_hi <= 0;
      else if (modr === 1'b1)
         n_hi <= n_hi + 1;
   ssc_spi_host host (.sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi), .miso_in(miso));
   ssc_config_bank dut (.mclk_in(mclk), .sys_rst_in(rst), .spi_sclk_in(sclk),
      .spi_cs_n_in(cs_n), .spi_mosi_in(mosi), .spi_miso_out(miso), .spi_miso_oe_out(miso_oe),
      .mute_n_in(mute_n), .pfd_tick_in(tick), .phase_in_window_in(win), .lock_out(lock),
      .stat_out(stat), .rf_mute_out(rfm), .mod_reset_out(modr), .fb_div_out(fb), .cfg_out(cfg));
   // ==========================================================
   // Tasks
   task automatic chk(input logic [17:0] got, input logic [17:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH at %0t: value %0h expected %0h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_bit(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask : chk_bit
   task automatic wr(input logic [6:0] a, input logic [7:0] d[$]);
      d.push_front({a, 1'b0});
      host.frame(d, rd);
      repeat (8) @(negedge mclk);
   endtask : wr
   task automatic rdr(input logic [6:0] a);
      logic [7:0] d[$];
      d = '{{a, 1'b1}, 8'h00};
      fork
         host.frame(d, rd);
         begin
            repeat (12) @(negedge sclk);
            chk_bit(miso_oe, 1'b1);
         end
      join
   endtask : rdr
   task automatic ticks(input int n, input logic w);
      repeat (n) begin
         @(negedge mclk);
         tick = 1'b1;
         win  = w;
         @(negedge mclk);
         tick = 1'b0;
      end
      repeat (3) @(negedge mclk);
   endtask : ticks
   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : final_report
   // ==========================================================
   // Scenarios
   initial begin
      #900000;
      n_fail++;
      $display("MISMATCH at %0t: run did not finish", $time);
      final_report();
   end
   initial begin
      repeat (16) @(negedge mclk);
      rst = 1'b0;
      repeat (8) @(negedge mclk);
      chk(18'(cfg.seed), 18'(RST_SEED));
      chk_bit(rfm, 1'b1);
      $display("test reset done");
      wr(7'h00, tbl);
      for (int a = 0; a < 15; a++) begin
         rdr(7'(a));
         chk(18'(rd), (a == 0 || a == 14) ? 18'h0 : 18'(tbl[a]));
      end
      chk(cfg.numerator, 18'h13646);
      chk(18'({cfg.regulator_enable, cfg.regulator_voltage_sel}), 18'h5);
      chk(18'({cfg.dither_enable, cfg.integer_mode_sel}), 18'h2);
      chk(18'({cfg.output_power_sel, cfg.output_divider_sel}), 18'h19);
      chk(18'({cfg.lock_window_sel, cfg.lock_count_sel, cfg.pump_current_sel}), 18'h55);
      chk(18'({cfg.pump_high_clamp_en, cfg.pump_low_clamp_en}), 18'h0);
      chk_bit(cfg.pump_polarity_invert, 1'b1);
      chk_bit(cfg.ref_filter_sel, 1'b0);
      wr(7'h0B, '{8'h19});
      chk_bit(cfg.ref_boost, 1'b0);
      $display("test burst done");
      mute_n = 1'b1;
      repeat (10) @(negedge mclk);
      chk_bit(rfm, 1'b1);
      wr(7'h02, '{8'h00});
      chk_bit(rfm, 1'b0);
      mute_n = 1'b0;
      repeat (10) @(negedge mclk);
      chk_bit(rfm, 1'b1);
      mute_n = 1'b1;
      $display("test mute done");
      wr(7'h03, '{8'h06});
      k = n_hi;
      wr(7'h02, '{8'h00});
      chk(18'(n_hi - k), 18'h1);
      wr(7'h08, '{8'h20, 8'h00, 8'h00});
      wr(7'h03, '{8'h09});
      chk_bit(modr, 1'b1);
      wr(7'h03, '{8'h01});
      chk_bit(modr, 1'b0);
      $display("test modulator reset done");
      for (int m = 0; m < 2; m++) begin
         if (m == 1)
            wr(7'h03, '{8'h00});
         for (int t = 0; t < 4; t++) begin
            ticks(1, 1'b1);
            chk(18'(fb), 18'h30 + 18'(m & t));
         end
      end
      $display("test divider done");
      ticks(1, 1'b0);
      ticks(31, 1'b1);
      chk_bit(lock, 1'b0);
      ticks(1, 1'b1);
      chk_bit(lock, 1'b1);
      chk_bit(stat, 1'b1);
      ticks(1, 1'b0);
      chk_bit(lock, 1'b0);
      wr(7'h01, '{8'h00});
      ticks(40, 1'b1);
      chk_bit(stat, 1'b0);
      rdr(7'h00);
      chk(18'(rd), 18'h1);
      $display("test lock done");
      final_report();
   end
endmodule : ssc_config_bank_bench
